// *** dbd_pkg.sv ***
package dbd_pkg;

  // ------------------------------------------------------------
  // Widths and depths
  // ------------------------------------------------------------
  localparam int ELEM_W = 16;
  localparam int BEAT_W = 2 * ELEM_W;
  localparam int BURST_W = 8 * ELEM_W;
  localparam int LAT_W = 5;
  localparam int PIPE_D = 32;
  localparam int TAG_N = 8;

  // ------------------------------------------------------------
  // Encodings and timing counts
  // ------------------------------------------------------------
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [1:0] BEAT_BC4_LAST = 2'h1;
  localparam logic [1:0] BEAT_BL8_LAST = 2'h3;
  localparam logic [1:0] DQS_TOGGLE = 2'h1;  // {late half, early half}
  localparam logic [1:0] DQS_LOW = 2'h0;
  localparam logic [1:0] OE_BOTH = 2'h0;
  localparam logic [1:0] OE_FIRST = 2'h2;
  localparam logic [1:0] OE_NONE = 2'h3;
  localparam logic [4:0] RD_LEAD = 5'h02;
  localparam logic [2:0] T_CCD_CK = 3'h4;
  localparam logic [4:0] T_WTR_CK = 5'h04;
  localparam logic [4:0] T_WR_CK = 5'h08;
  localparam logic [4:0] BC4_SHIFT_CK = 5'h02;
  localparam logic [3:0] TAG_FULL = 4'h8;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {CMD_NOP, CMD_RD, CMD_WR, CMD_PRE} dbd_cmd_e;
  typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_DATA, PH_POST} dbd_ph_e;

  typedef struct packed {
    logic       vld;
    logic       bc4;
    logic       fix;
    logic       ap;
    logic [2:0] bank;
    logic [9:0] col;
  } dbd_desc_s;

  // Burst chop from mode field and A12
  function automatic logic dbd_bc4(input logic [1:0] bl, input logic a12);
    dbd_bc4 = (bl == BL_FIX4) || (bl == BL_OTF && !a12);
  endfunction : dbd_bc4

endpackage : dbd_pkg

// *** dbd_link_if.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Link between controller and memory device
// ------------------------------------------------------------
interface dbd_link_if;
  import dbd_pkg::*;
  logic                ck;
  dbd_cmd_e            cmd;
  logic [2:0]          ba;
  logic [9:0]          col;
  logic                ap;
  logic                a12;
  logic                odt;
  logic [1:0]          dm;
  logic [BEAT_W-1:0]   ctl_dq;
  logic                ctl_dq_oe_n;
  logic [1:0]          ctl_dqs;
  logic [1:0]          ctl_dqs_oe_n;
  logic [BEAT_W-1:0]   dev_dq;
  logic                dev_dq_oe_n;
  logic [1:0]          dev_dqs;
  logic [1:0]          dev_dqs_oe_n;
  logic                dq_term;
  logic [BEAT_W-1:0]   dq;
  logic [1:0]          dqs;
  logic [1:0]          dqs_c;

  // Wire levels from the enables
  assign dq = !dev_dq_oe_n ? dev_dq : (!ctl_dq_oe_n ? ctl_dq : '0);
  assign dqs = (~dev_dqs_oe_n & dev_dqs) | (~ctl_dqs_oe_n & ctl_dqs);
  assign dqs_c = ~dqs;

  modport dev (input ck, cmd, ba, col, ap, a12, odt, dm, dq, dqs,
               output dev_dq, dev_dq_oe_n, dev_dqs, dev_dqs_oe_n, dq_term);
  modport ctl (output ck, cmd, ba, col, ap, a12, odt, dm, ctl_dq,
               ctl_dq_oe_n, ctl_dqs, ctl_dqs_oe_n,
               input dq, dqs, dev_dq_oe_n, dev_dqs_oe_n);
endinterface : dbd_link_if

// *** dbd_dev.sv ***
`timescale 1ns/1ps
module dbd_dev
  import dbd_pkg::*;
(
  dbd_link_if.dev           link,       // Link to controller
  input  wire logic         rst_n_i,    // Async reset
  input  wire logic         en_i,       // Clock enable
  input  wire logic [1:0]   mr_bl_i,    // Burst mode field
  input  wire logic [3:0]   mr_al_i,    // Additive latency
  input  wire logic [3:0]   mr_cl_i,    // CAS latency
  input  wire logic [3:0]   mr_cwl_i,   // CAS write latency
  output logic [1:0]        wr_en_o,    // Element write enables
  output logic [2:0]        wr_bank_o,  // Write bank
  output logic [9:0]        wr_col_o,   // Column of low element
  output logic [BEAT_W-1:0] wr_data_o,  // Two write elements
  output logic [2:0]        rd_bank_o,  // Read bank lookup
  output logic [9:0]        rd_col_o,   // Read column lookup
  input  wire logic [BEAT_W-1:0] rd_data_i, // Two read elements
  output logic              ap_o,       // Auto precharge pulse
  output logic [2:0]        ap_bank_o   // Precharged bank
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    dbd_desc_s [PIPE_D-1:0] wpipe;
    dbd_desc_s [PIPE_D-1:0] rpipe;
    logic                   wact;
    logic [1:0]             wbeat;
    dbd_desc_s              wcur;
    dbd_ph_e                rph;
    logic [1:0]             rbeat;
    dbd_desc_s              rcur;
    dbd_desc_s              rnxt;
    logic [1:0]             wr_en;
    logic [2:0]             wr_bank;
    logic [9:0]             wr_col;
    logic [BEAT_W-1:0]      wr_data;
    logic                   ap;
    logic [2:0]             ap_bank;
    logic [BEAT_W-1:0]      dq;
    logic                   dq_oe_n;
    logic [1:0]             dqs;
    logic [1:0]             dqs_oe_n;
    logic                   term;
  } dbd_dev_s;

  dbd_dev_s         s_q;
  dbd_dev_s         s_d;
  logic [LAT_W-1:0] wl;
  logic [LAT_W-1:0] rl;
  dbd_desc_s        dsc;
  dbd_desc_s        wp;
  dbd_desc_s        rp;
  dbd_desc_s        wc;
  logic [1:0]       wb;
  logic             wa;
  logic             take;

  // Latencies from mode fields
  assign wl = {1'b0, mr_al_i} + {1'b0, mr_cwl_i};
  assign rl = {1'b0, mr_al_i} + {1'b0, mr_cl_i};

  // Descriptor of the command on the link
  always_comb begin
    dsc      = '0;
    dsc.vld  = 1'b1;
    dsc.bc4  = dbd_bc4(mr_bl_i, link.a12);
    dsc.fix  = (mr_bl_i == BL_FIX4);
    dsc.ap   = link.ap;
    dsc.bank = link.ba;
    dsc.col  = link.col;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d  = s_q;
    wp   = s_q.wpipe[0];
    rp   = s_q.rpipe[0];
    wc   = s_q.wcur;
    wb   = s_q.wbeat;
    wa   = s_q.wact;
    take = 1'b0;
    if (en_i) begin
      // Latency pipes advance one slot per clock
      s_d.wpipe[PIPE_D-2:0] = s_q.wpipe[PIPE_D-1:1];
      s_d.wpipe[PIPE_D-1]   = '0;
      s_d.rpipe[PIPE_D-2:0] = s_q.rpipe[PIPE_D-1:1];
      s_d.rpipe[PIPE_D-1]   = '0;
      if (link.cmd == CMD_WR) begin
        s_d.wpipe[wl] = dsc;
      end
      if (link.cmd == CMD_RD) begin
        s_d.rpipe[rl - RD_LEAD] = dsc;
      end

      // Write capture, new burst takes over seamlessly
      s_d.wr_en = '0;
      s_d.ap    = 1'b0;
      if (wp.vld) begin
        wc = wp;
        wb = '0;
        wa = 1'b1;
      end
      if (wa) begin
        take = (wb <= BEAT_BC4_LAST || !wc.bc4) && link.dqs == DQS_TOGGLE;
        s_d.wr_en   = {2{take}} & ~link.dm;
        s_d.wr_bank = wc.bank;
        s_d.wr_col  = wc.col + 10'({wb, 1'b0});
        s_d.wr_data = link.dq;
        if (wc.ap && wb == (wc.fix ? BEAT_BC4_LAST : BEAT_BL8_LAST)) begin
          s_d.ap      = 1'b1;
          s_d.ap_bank = wc.bank;
        end
        s_d.wact  = (wb != BEAT_BL8_LAST);
        s_d.wbeat = wb + 2'h1;
        s_d.wcur  = wc;
      end

      // Read strobe phases
      unique case (s_q.rph)
        PH_IDLE, PH_POST: begin
          if (rp.vld) begin
            s_d.rph  = PH_PRE;
            s_d.rcur = rp;
          end else begin
            s_d.rph = PH_IDLE;
          end
        end
        PH_PRE: begin
          s_d.rph   = PH_DATA;
          s_d.rbeat = '0;
        end
        PH_DATA: begin
          if (rp.vld) begin
            s_d.rnxt = rp;
          end
          if (s_q.rbeat == (s_q.rcur.bc4 ? BEAT_BC4_LAST : BEAT_BL8_LAST)) begin
            if (s_d.rnxt.vld) begin
              s_d.rcur  = s_d.rnxt;
              s_d.rnxt  = '0;
              s_d.rbeat = '0;
            end else begin
              s_d.rph = PH_POST;
            end
          end else begin
            s_d.rbeat = s_q.rbeat + 2'h1;
          end
        end
      endcase

      // Pin drive from the new phase
      s_d.dq_oe_n  = 1'b1;
      s_d.dqs      = DQS_LOW;
      s_d.dqs_oe_n = OE_NONE;
      unique case (s_d.rph)
        PH_IDLE: begin
          s_d.dqs_oe_n = OE_NONE;
        end
        PH_PRE: begin
          s_d.dqs_oe_n = OE_BOTH;
        end
        PH_DATA: begin
          s_d.dqs      = DQS_TOGGLE;
          s_d.dqs_oe_n = OE_BOTH;
          s_d.dq_oe_n  = 1'b0;
          s_d.dq       = rd_data_i;
        end
        PH_POST: begin
          s_d.dqs_oe_n = OE_FIRST;
        end
      endcase

      // Termination only while not driving
      s_d.term = link.odt && s_d.dq_oe_n;
    end
  end

  // Element lookup for the beat about to be driven
  assign rd_bank_o = s_d.rcur.bank;
  assign rd_col_o  = s_d.rcur.col + 10'({s_d.rbeat, 1'b0});

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge link.ck or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q          <= '0;
      s_q.dq_oe_n  <= 1'b1;
      s_q.dqs_oe_n <= OE_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign wr_en_o           = s_q.wr_en;
  assign wr_bank_o         = s_q.wr_bank;
  assign wr_col_o          = s_q.wr_col;
  assign wr_data_o         = s_q.wr_data;
  assign ap_o              = s_q.ap;
  assign ap_bank_o         = s_q.ap_bank;
  assign link.dev_dq       = s_q.dq;
  assign link.dev_dq_oe_n  = s_q.dq_oe_n;
  assign link.dev_dqs      = s_q.dqs;
  assign link.dev_dqs_oe_n = s_q.dqs_oe_n;
  assign link.dq_term      = s_q.term;

endmodule : dbd_dev

// *** dbd_ctl.sv ***
`timescale 1ns/1ps
module dbd_ctl
  import dbd_pkg::*;
(
  input  wire logic          clk_i,       // System clock
  input  wire logic          rst_n_i,     // Async reset
  input  wire logic          en_i,        // Clock enable
  dbd_link_if.ctl            link,        // Link to device
  input  wire logic [1:0]    mr_bl_i,     // Burst mode field
  input  wire logic [3:0]    mr_al_i,     // Additive latency
  input  wire logic [3:0]    mr_cwl_i,    // CAS write latency
  input  wire logic          req_valid_i, // Request valid
  output logic               req_ready_o, // Request taken
  input  wire dbd_cmd_e      req_cmd_i,   // Command
  input  wire logic [2:0]    req_bank_i,  // Bank
  input  wire logic [9:0]    req_col_i,   // Column
  input  wire logic          req_ap_i,    // Auto precharge
  input  wire logic          req_a12_i,   // Chop select
  input  wire logic          odt_i,       // Termination level
  input  wire logic [BURST_W-1:0] wdata_i, // Eight write elements
  input  wire logic [7:0]    wmask_i,     // Element masks
  output logic               rd_valid_o,  // Read beat pulse
  output logic [BEAT_W-1:0]  rd_data_o    // Two read elements
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic       vld;
    logic       bc4;
    logic       fix;
    logic [2:0] tag;
  } dbd_slot_s;

  typedef struct packed {
    logic                             ph;
    logic                             ck;
    dbd_cmd_e                         cmd;
    logic [2:0]                       ba;
    logic [9:0]                       col;
    logic                             ap;
    logic                             a12;
    logic                             odt;
    logic [BEAT_W-1:0]                dq;
    logic                             dq_oe_n;
    logic [1:0]                       dm;
    logic [1:0]                       dqs;
    logic [1:0]                       dqs_oe_n;
    dbd_slot_s [PIPE_D-1:0]           wpipe;
    dbd_ph_e                          wph;
    logic [1:0]                       wbeat;
    dbd_slot_s                        wcur;
    dbd_slot_s                        wnxt;
    logic [2:0]                       tag;
    logic [3:0]                       outs;
    logic [TAG_N-1:0][BURST_W-1:0]    wbuf;
    logic [TAG_N-1:0][7:0]            wmsk;
    logic [2:0]                       ccd;
    logic [4:0]                       wtr;
    logic [4:0]                       wr;
    logic                             rd_valid;
    logic [BEAT_W-1:0]                rd_data;
  } dbd_ctl_s;

  dbd_ctl_s         s_q;
  dbd_ctl_s         s_d;
  logic [LAT_W-1:0] wl;
  logic             tick;
  logic             take;
  logic             done;
  dbd_slot_s        wp;

  assign wl   = {1'b0, mr_al_i} + {1'b0, mr_cwl_i};
  assign tick = en_i && s_q.ph;

  // Spacing gates on read, write and precharge, pending write data blocks read and precharge
  always_comb begin
    unique case (req_cmd_i)
      CMD_RD:  req_ready_o = tick && s_q.ccd == '0 && s_q.outs == '0 && s_q.wtr == '0;
      CMD_WR:  req_ready_o = tick && s_q.ccd == '0 && s_q.outs != TAG_FULL;
      CMD_PRE: req_ready_o = tick && s_q.outs == '0 && s_q.wr == '0;
      CMD_NOP: req_ready_o = tick;
    endcase
  end
  assign take = req_valid_i && req_ready_o;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    wp       = s_q.wpipe[0];
    done     = 1'b0;
    s_d.rd_valid = 1'b0;
    if (en_i) begin
      s_d.ph = !s_q.ph;
      s_d.ck = !s_q.ph;  // Divide by two
    end
    // Sample device at the rising link edge
    if (en_i && !s_q.ph) begin
      if (!link.dev_dq_oe_n && link.dev_dqs_oe_n == OE_BOTH && link.dqs == DQS_TOGGLE) begin
        s_d.rd_valid = 1'b1;
        s_d.rd_data  = link.dq;
      end
    end
    if (tick) begin
      s_d.cmd = CMD_NOP;
      s_d.odt = odt_i;
      s_d.wpipe[PIPE_D-2:0] = s_q.wpipe[PIPE_D-1:1];
      s_d.wpipe[PIPE_D-1]   = '0;
      if (s_q.ccd != '0) s_d.ccd = s_q.ccd - 3'h1;
      if (s_q.wtr != '0) s_d.wtr = s_q.wtr - 5'h01;
      if (s_q.wr != '0) s_d.wr = s_q.wr - 5'h01;
      if (take) begin
        s_d.cmd = req_cmd_i;
        s_d.ba  = req_bank_i;
        s_d.col = req_col_i;
        s_d.ap  = req_ap_i;
        s_d.a12 = req_a12_i;
        if (req_cmd_i == CMD_RD || req_cmd_i == CMD_WR) begin
          s_d.ccd = T_CCD_CK - 3'h1;
        end
        if (req_cmd_i == CMD_WR) begin
          s_d.wbuf[s_q.tag] = wdata_i;
          s_d.wmsk[s_q.tag] = wmask_i;
          s_d.wpipe[wl - 5'h01] = '{1'b1, dbd_bc4(mr_bl_i, req_a12_i),
                                    mr_bl_i == BL_FIX4, s_q.tag};
          s_d.tag = s_q.tag + 3'h1;
        end
      end
      // Write strobe phases
      unique case (s_q.wph)
        PH_IDLE, PH_POST: begin
          s_d.wph = wp.vld ? PH_PRE : PH_IDLE;
          if (wp.vld) s_d.wcur = wp;
        end
        PH_PRE: begin
          s_d.wph   = PH_DATA;
          s_d.wbeat = '0;
        end
        PH_DATA: begin
          if (wp.vld) s_d.wnxt = wp;
          if (s_q.wbeat == (s_q.wcur.bc4 ? BEAT_BC4_LAST : BEAT_BL8_LAST)) begin
            done    = 1'b1;
            s_d.wtr = T_WTR_CK + ((s_q.wcur.bc4 && !s_q.wcur.fix) ? BC4_SHIFT_CK : '0);
            s_d.wr  = T_WR_CK + ((s_q.wcur.bc4 && !s_q.wcur.fix) ? BC4_SHIFT_CK : '0);
            if (s_d.wnxt.vld) begin
              s_d.wcur  = s_d.wnxt;
              s_d.wnxt  = '0;
              s_d.wbeat = '0;
            end else begin
              s_d.wph = PH_POST;
            end
          end else begin
            s_d.wbeat = s_q.wbeat + 2'h1;
          end
        end
      endcase
      s_d.outs = s_q.outs + 4'((take && req_cmd_i == CMD_WR)) - 4'(done);
      // Pin drive
      s_d.dq_oe_n  = 1'b1;
      s_d.dm       = '0;
      s_d.dqs      = DQS_LOW;
      s_d.dqs_oe_n = OE_NONE;
      unique case (s_d.wph)
        PH_IDLE: s_d.dqs_oe_n = OE_NONE;
        PH_PRE: begin
          s_d.dqs      = DQS_TOGGLE;
          s_d.dqs_oe_n = OE_BOTH;
        end
        PH_DATA: begin
          s_d.dqs      = DQS_TOGGLE;
          s_d.dqs_oe_n = OE_BOTH;
          s_d.dq_oe_n  = 1'b0;
          s_d.dq = s_q.wbuf[s_d.wcur.tag][{s_d.wbeat, 5'h00} +: BEAT_W];
          s_d.dm = s_q.wmsk[s_d.wcur.tag][{s_d.wbeat, 1'b0} +: 2];
        end
        PH_POST: s_d.dqs_oe_n = OE_FIRST;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q          <= '0;
      s_q.dq_oe_n  <= 1'b1;
      s_q.dqs_oe_n <= OE_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.ck           = s_q.ck;
  assign link.cmd          = s_q.cmd;
  assign link.ba           = s_q.ba;
  assign link.col          = s_q.col;
  assign link.ap           = s_q.ap;
  assign link.a12          = s_q.a12;
  assign link.odt          = s_q.odt;
  assign link.dm           = s_q.dm;
  assign link.ctl_dq       = s_q.dq;
  assign link.ctl_dq_oe_n  = s_q.dq_oe_n;
  assign link.ctl_dqs      = s_q.dqs;
  assign link.ctl_dqs_oe_n = s_q.dqs_oe_n;
  assign rd_valid_o        = s_q.rd_valid;
  assign rd_data_o         = s_q.rd_data;

endmodule : dbd_ctl

// *** dbd_link_properties.sv ***
`timescale 1ns/1ps
module dbd_link_properties
  import dbd_pkg::*;
(
  input wire logic       ck,           // Link clock
  input wire logic       rst_n_i,      // Async reset
  input wire dbd_cmd_e   cmd,          // Command
  input wire logic       odt,          // Termination request
  input wire logic       dev_dq_oe_n,  // Device data enable
  input wire logic [1:0] dev_dqs,      // Device strobe
  input wire logic [1:0] dev_dqs_oe_n, // Device strobe enable
  input wire logic       dq_term,      // Termination active
  input wire logic       ctl_dq_oe_n,  // Controller data enable
  input wire logic [1:0] ctl_dqs,      // Controller strobe
  input wire logic [1:0] ctl_dqs_oe_n  // Controller strobe enable
);
  // ----
  // Link checks, read and write latency 5
  // ----
  default clocking cb @(posedge ck); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_pre;
    dev_dqs_oe_n == OE_BOTH && dev_dqs == DQS_LOW && dev_dq_oe_n;
  endsequence
  sequence s_rd_beat;
    !dev_dq_oe_n && dev_dqs == DQS_TOGGLE;
  endsequence
  sequence s_wr_beat;
    !ctl_dq_oe_n && ctl_dqs == DQS_TOGGLE;
  endsequence
  property p_rd_pre;
    cmd == CMD_RD |-> ##5 s_rd_pre;
  endproperty
  a_rd_pre: assert property (p_rd_pre) else $error("read preamble late");
  property p_rd_data;
    cmd == CMD_RD |-> ##6 s_rd_beat [*2];
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data late");
  property p_rd_post;
    $rose(dev_dqs_oe_n[1]) && !dev_dqs_oe_n[0] |-> dev_dqs == DQS_LOW ##1 dev_dqs_oe_n == OE_NONE;
  endproperty
  a_rd_post: assert property (p_rd_post) else $error("read postamble bad");
  property p_wr_quiet;
    cmd == CMD_WR && dev_dqs_oe_n == OE_NONE |=> (dev_dqs_oe_n == OE_NONE && dev_dq_oe_n) [*8];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("device drives in write");
  property p_term_on;
    (odt && dev_dq_oe_n) [*3] |-> dq_term;
  endproperty
  a_term_on: assert property (p_term_on) else $error("termination off");
  property p_term_off;
    !dev_dq_oe_n [*2] |-> !dq_term;
  endproperty
  a_term_off: assert property (p_term_off) else $error("termination while driving");
  property p_wr_pre;
    cmd == CMD_WR |-> ##5 ctl_dqs_oe_n == OE_BOTH ##1 s_wr_beat [*2];
  endproperty
  a_wr_pre: assert property (p_wr_pre) else $error("write strobe late");
  property p_wr_post;
    $rose(ctl_dqs_oe_n[1]) && !ctl_dqs_oe_n[0] |-> ctl_dqs == DQS_LOW ##1 ctl_dqs_oe_n == OE_NONE;
  endproperty
  a_wr_post: assert property (p_wr_post) else $error("write postamble bad");
  property p_ccd;
    cmd inside {CMD_RD, CMD_WR} |=> !(cmd inside {CMD_RD, CMD_WR}) [*3];
  endproperty
  a_ccd: assert property (p_ccd) else $error("column commands too close");
endmodule : dbd_link_properties

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import dbd_pkg::*;
  localparam int WL = 5;
  logic           clk_i = 1'b0;
  logic           rst_n_i = 1'b0;
  logic [1:0]     mr_bl = BL_FIX8;
  logic           odt = 1'b1;
  logic           en = 1'b1;
  logic           rq_v = 1'b0;
  dbd_cmd_e       rq_cmd = CMD_NOP;
  logic [2:0]     rq_bank = 3'h0;
  logic [9:0]     rq_col = 10'h000;
  logic           rq_ap = 1'b0;
  logic           rq_a12 = 1'b0;
  logic [127:0]   wdata = '0;
  logic [7:0]     wmask = 8'h00;
  logic           req_ready, rd_valid, ap;
  logic [31:0]    rd_data, wr_data, rd_mem;
  logic [1:0]     wr_en;
  logic [2:0]     wr_bank, rd_bank, ap_bank, ap_bank_seen;
  logic [9:0]     wr_col, rd_col;
  logic [15:0]    mem [0:8191];
  logic [15:0]    shd [0:8191];
  int             errors = 0, checks = 0, wr_cnt = 0, ap_cnt = 0;
  longint         acc, t0;
  // ----
  // Clock, link, ends and storage
  // ----
  always #5 clk_i = ~clk_i;
  dbd_link_if dbd_link_if_inst ();
  dbd_ctl dbd_ctl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en),
    .link(dbd_link_if_inst.ctl), .mr_bl_i(mr_bl), .mr_al_i(4'h1), .mr_cwl_i(4'h4),
    .req_valid_i(rq_v), .req_ready_o(req_ready), .req_cmd_i(rq_cmd), .req_bank_i(rq_bank),
    .req_col_i(rq_col), .req_ap_i(rq_ap), .req_a12_i(rq_a12), .odt_i(odt),
    .wdata_i(wdata), .wmask_i(wmask), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  dbd_dev dbd_dev_inst (.link(dbd_link_if_inst.dev), .rst_n_i(rst_n_i), .en_i(en),
    .mr_bl_i(mr_bl), .mr_al_i(4'h1), .mr_cl_i(4'h4), .mr_cwl_i(4'h4), .wr_en_o(wr_en),
    .wr_bank_o(wr_bank), .wr_col_o(wr_col), .wr_data_o(wr_data), .rd_bank_o(rd_bank),
    .rd_col_o(rd_col), .rd_data_i(rd_mem), .ap_o(ap), .ap_bank_o(ap_bank));
  dbd_link_properties dbd_link_properties_inst (.ck(dbd_link_if_inst.ck),
    .rst_n_i(rst_n_i), .cmd(dbd_link_if_inst.cmd), .odt(dbd_link_if_inst.odt),
    .dev_dq_oe_n(dbd_link_if_inst.dev_dq_oe_n), .dev_dqs(dbd_link_if_inst.dev_dqs),
    .dev_dqs_oe_n(dbd_link_if_inst.dev_dqs_oe_n), .dq_term(dbd_link_if_inst.dq_term),
    .ctl_dq_oe_n(dbd_link_if_inst.ctl_dq_oe_n), .ctl_dqs(dbd_link_if_inst.ctl_dqs),
    .ctl_dqs_oe_n(dbd_link_if_inst.ctl_dqs_oe_n));
  // Array answers the device combinationally
  assign rd_mem = {mem[{rd_bank, rd_col + 10'h001}], mem[{rd_bank, rd_col}]};
  // Store written elements, count them and precharges
  always @(negedge dbd_link_if_inst.ck) begin
    for (int e = 0; e < 2; e++) begin
      if (wr_en[e] === 1'b1) begin
        mem[{wr_bank, wr_col + e[9:0]}] = wr_data[16*e +: 16];
        wr_cnt++;
      end
    end
    if (ap === 1'b1) begin
      ap_cnt++;
      ap_bank_seen = ap_bank;
    end
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic req(input dbd_cmd_e c, input logic [2:0] b, input logic [9:0] col,
                     input logic apb, input logic a12);
    int n;
    @(negedge clk_i);
    rq_cmd = c;
    rq_bank = b;
    rq_col = col;
    rq_ap = apb;
    rq_a12 = a12;
    rq_v = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    acc = $time;
    @(negedge clk_i);
    rq_v = 1'b0;
    if (n >= 200) chk("ready", 1, 0);
  endtask : req
  task automatic wr(input logic [2:0] b, input logic [9:0] col, input logic a12,
                    input logic apb, input logic [7:0] m, input logic [15:0] sd, input int ne);
    for (int k = 0; k < 8; k++) begin
      wdata[16*k +: 16] = sd + 16'(k);
      if (k < ne && !m[k]) shd[{b, col + 10'(k)}] = sd + 16'(k);
    end
    wmask = m;
    req(CMD_WR, b, col, apb, a12);
  endtask : wr
  task automatic rd(input logic [2:0] b, input logic [9:0] col, input logic a12, input int nb);
    int n;
    req(CMD_RD, b, col, 1'b0, a12);
    n = 0;
    repeat (40) begin
      @(negedge clk_i);
      if (rd_valid === 1'b1) begin
        chk("rd_data", {shd[{b, col + 10'(2*n+1)}], shd[{b, col + 10'(2*n)}]}, rd_data);
        n++;
      end
    end
    chk("rd_beats", nb, n);
  endtask : rd
  task automatic t_modes;
    int ne;
    for (int m = 0; m < 4; m++) begin
      mr_bl = m == 3 ? BL_FIX4 : (m == 0 ? BL_FIX8 : BL_OTF);
      ne = m < 2 ? 8 : 4;
      wr_cnt = 0;
      ap_cnt = 0;
      wr(3'(m), 10'h020, m[0], 1'b0, 8'h00, 16'h1000 * 16'(m + 1), ne);
      repeat (30) @(negedge clk_i);
      chk("wr_elems", ne, wr_cnt);
      chk("ap_none", 0, ap_cnt);
      rd(3'(m), 10'h020, m[0], ne / 2);
    end
  endtask : t_modes
  task automatic t_mask_ap;
    mr_bl = BL_FIX8;
    wr_cnt = 0;
    ap_cnt = 0;
    wr(3'h5, 10'h040, 1'b1, 1'b1, 8'h81, 16'h7700, 8);
    repeat (30) @(negedge clk_i);
    chk("wr_elems", 6, wr_cnt);
    chk("ap_cnt", 1, ap_cnt);
    chk("ap_bank", 5, ap_bank_seen);
    rd(3'h5, 10'h040, 1'b1, 4);
  endtask : t_mask_ap
  task automatic t_concat;
    wr_cnt = 0;
    wr(3'h2, 10'h060, 1'b0, 1'b0, 8'h00, 16'h2200, 8);
    t0 = acc;
    wr(3'h2, 10'h068, 1'b0, 1'b0, 8'h10, 16'h3300, 8);
    chk("ccd_gap", 2 * T_CCD_CK, 32'((acc - t0) / 10));
    repeat (40) @(negedge clk_i);
    chk("wr_elems", 15, wr_cnt);
    rd(3'h2, 10'h060, 1'b0, 4);
    rd(3'h2, 10'h068, 1'b0, 4);
  endtask : t_concat
  task automatic t_recov;
    logic [31:0] g [4];
    odt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      mr_bl = i[0] ? BL_FIX4 : BL_FIX8;
      wr(3'h6, 10'h080, 1'b0, 1'b0, 8'h00, 16'h4400, i[0] ? 4 : 8);
      t0 = acc;
      req(i[1] ? CMD_PRE : CMD_RD, 3'h6, 10'h080, 1'b0, 1'b0);
      g[i] = 32'((acc - t0) / 10);
      repeat (40) @(negedge clk_i);
    end
    chk("wtr_bc4", g[0] - 4, g[1]);
    chk("wr_bc4", g[2] - 4, g[3]);
    chk("wtr_min", 1, 32'(g[0] >= 2 * (WL + 4 + T_WTR_CK) - 2));
    chk("wr_min", 1, 32'(g[2] >= 2 * (WL + 4 + T_WR_CK) - 2));
  endtask : t_recov
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // Main sequence
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 16'(i) ^ 16'h5a5a;
      shd[i] = 16'(i) ^ 16'h5a5a;
    end
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_modes();
    t_mask_ap();
    t_concat();
    t_recov();
    results();
  end
  // Watchdog
  initial begin
    #100000;
    errors++;
    results();
  end
endmodule : tb
